// ---- core/mcu8_defines.svh ----
// Constants of the 8-bit microcontroller core: widths, vectors and instruction encoding.
`ifndef MCU8_DEFINES_SVH
`define MCU8_DEFINES_SVH

// Widths.
`define MCU8_PC_W        10
`define MCU8_INSTR_W     18
`define MCU8_DATA_W      8

// Program addresses.
`define MCU8_RESET_PC    10'h000
`define MCU8_INT_VECTOR  10'h3ff

// Instruction fields.
`define MCU8_OP_HI       17
`define MCU8_OP_LO       13
`define MCU8_REGSRC_BIT  12
`define MCU8_SX_HI       11
`define MCU8_SX_LO       8
`define MCU8_SY_HI       7
`define MCU8_SY_LO       4
`define MCU8_COND_HI     12
`define MCU8_COND_LO     10

// Opcodes in bits 17:13; bit 12 selects register (1) or constant (0) operand.
`define MCU8_OP_LOAD     5'h00
`define MCU8_OP_AND      5'h01
`define MCU8_OP_OR       5'h02
`define MCU8_OP_XOR      5'h03
`define MCU8_OP_ADD      5'h04
`define MCU8_OP_ADDC     5'h05
`define MCU8_OP_SUB      5'h06
`define MCU8_OP_SUBC     5'h07
`define MCU8_OP_CMP      5'h08
`define MCU8_OP_TEST     5'h09
`define MCU8_OP_SHIFT    5'h0a
`define MCU8_OP_INPUT    5'h0b
`define MCU8_OP_OUTPUT   5'h0c
`define MCU8_OP_FETCH    5'h0d
`define MCU8_OP_STORE    5'h0e
`define MCU8_OP_JUMP     5'h10
`define MCU8_OP_CALL     5'h11
`define MCU8_OP_RETURN   5'h12
`define MCU8_OP_RETI     5'h13
`define MCU8_OP_INTEN    5'h14

// Shift sub-operations in bits 1:0.
`define MCU8_SH_SL0      2'h0
`define MCU8_SH_SR0      2'h1
`define MCU8_SH_RL       2'h2
`define MCU8_SH_RR       2'h3

// Branch conditions in bits 12:10.
`define MCU8_CC_ALWAYS   3'h0
`define MCU8_CC_Z        3'h4
`define MCU8_CC_NZ       3'h5
`define MCU8_CC_C        3'h6
`define MCU8_CC_NC       3'h7

`endif

// ---- core/mcu8_pkg.sv ----
// Types shared by the 8-bit microcontroller core and its arithmetic unit.
`include "mcu8_defines.svh"
package mcu8_pkg;
    typedef logic [`MCU8_DATA_W-1:0]  mcu8_byte_t;
    typedef logic [`MCU8_PC_W-1:0]    mcu8_pc_t;
    typedef logic [`MCU8_INSTR_W-1:0] mcu8_instr_t;
    typedef logic [4:0]               mcu8_op_t;
    typedef enum logic {
        MCU8_PH_FETCH,
        MCU8_PH_EXEC
    } mcu8_phase_t;
endpackage : mcu8_pkg

// ---- core/mcu8_alu.sv ----
// Arithmetic and logic unit of the 8-bit microcontroller core.
`include "mcu8_defines.svh"
module mcu8_alu
    import mcu8_pkg::*;
(
    // Operation select.
    input  wire mcu8_op_t   op,
    input  wire logic [1:0] shift_sel,
    // Operands and carry in.
    input  wire mcu8_byte_t op_a,
    input  wire mcu8_byte_t op_b,
    input  wire logic       carry_in,
    // Result and flags.
    output mcu8_byte_t      result,
    output logic            zero,
    output logic            carry,
    output logic            write_en
);
    logic [8:0] wide;

    // Result, carry and register write; compare and test only touch the flags.
    always_comb begin
        wide     = 9'h000;
        result   = op_a;
        carry    = 1'b0;
        write_en = 1'b1;
        case (op)
            `MCU8_OP_LOAD: result = op_b;
            `MCU8_OP_AND:  result = op_a & op_b;
            `MCU8_OP_OR:   result = op_a | op_b;
            `MCU8_OP_XOR:  result = op_a ^ op_b;
            `MCU8_OP_ADD, `MCU8_OP_ADDC: begin
                wide   = {1'b0, op_a} + {1'b0, op_b}
                       + {8'h00, (op == `MCU8_OP_ADDC) & carry_in};
                result = wide[7:0];
                carry  = wide[8];
            end
            `MCU8_OP_SUB, `MCU8_OP_SUBC, `MCU8_OP_CMP: begin
                // Borrow shows as carry so that unsigned compares read naturally.
                wide     = {1'b0, op_a} - {1'b0, op_b}
                         - {8'h00, (op == `MCU8_OP_SUBC) & carry_in};
                result   = wide[7:0];
                carry    = wide[8];
                write_en = (op != `MCU8_OP_CMP);
            end
            `MCU8_OP_TEST: begin
                result   = op_a & op_b;
                carry    = ^(op_a & op_b); // Odd parity of the masked bits.
                write_en = 1'b0;
            end
            `MCU8_OP_SHIFT: begin
                case (shift_sel)
                    `MCU8_SH_SL0: begin
                        result = {op_a[6:0], 1'b0};
                        carry  = op_a[7];
                    end
                    `MCU8_SH_SR0: begin
                        result = {1'b0, op_a[7:1]};
                        carry  = op_a[0];
                    end
                    `MCU8_SH_RL: begin
                        result = {op_a[6:0], op_a[7]};
                        carry  = op_a[7];
                    end
                    default: begin
                        result = {op_a[0], op_a[7:1]};
                        carry  = op_a[0];
                    end
                endcase
            end
            default: write_en = 1'b0;
        endcase
        zero = (result == 8'h00);
    end
endmodule : mcu8_alu

// ---- core/mcu8_core.sv ----
// Top level of the 8-bit microcontroller core with two-cycle instruction execution.
`include "mcu8_defines.svh"
module mcu8_core
    import mcu8_pkg::*;
#(
    parameter int NUM_REGS      = 16,
    parameter int SCRATCH_DEPTH = 64,
    parameter int STACK_DEPTH   = 31
) (
    // Clock and synchronous reset.
    input  wire logic        clk,
    input  wire logic        srst,
    // Program store.
    output mcu8_pc_t         instr_addr,
    input  wire mcu8_instr_t instr,
    // Port bus.
    output mcu8_byte_t       io_select_address,
    output mcu8_byte_t       out_port,
    input  wire mcu8_byte_t  in_port,
    output logic             read_pulse,
    output logic             write_pulse,
    // Interrupt.
    input  wire logic        int_req,
    output logic             int_ack
);
    // The select and register fields are four bits wide and the stack pointer five.
    if (NUM_REGS != 16 || SCRATCH_DEPTH < 1 || SCRATCH_DEPTH > 256
        || STACK_DEPTH < 2 || STACK_DEPTH > 31) begin : g_bad_params
        $error("mcu8_core: unsupported register, scratch or stack size");
    end

    mcu8_phase_t phase_r;
    mcu8_pc_t    pc_r;
    mcu8_byte_t  regs_r    [NUM_REGS];
    mcu8_byte_t  scratch_r [SCRATCH_DEPTH];
    mcu8_pc_t    stack_r   [STACK_DEPTH];
    logic [4:0]  sp_r;
    logic        zero_r, carry_r, zero_save_r, carry_save_r;
    logic        int_en_r, int_req_d_r;
    logic [3:0]  in_dest_r;

    // Decoded instruction fields.
    mcu8_op_t    op;
    logic [3:0]  sx, sy;
    mcu8_byte_t  val_x, operand;
    logic [2:0]  cond;
    mcu8_pc_t    target, pc_inc, pc_nxt;
    logic        exec, take_int, cond_ok;
    logic [4:0]  sp_dec, sp_inc;
    mcu8_byte_t  alu_res;
    logic        alu_zero, alu_carry, alu_we;

    // Branch condition test against the current flags.
    function automatic logic cond_met(input logic [2:0] cc, input logic z, input logic c);
        case (cc)
            `MCU8_CC_ALWAYS: cond_met = 1'b1;
            `MCU8_CC_Z:      cond_met = z;
            `MCU8_CC_NZ:     cond_met = ~z;
            `MCU8_CC_C:      cond_met = c;
            `MCU8_CC_NC:     cond_met = ~c;
            default:         cond_met = 1'b0;
        endcase
    endfunction : cond_met

    // Scratch address from a constant or register, folded into the memory depth.
    function automatic int scratch_index(input mcu8_byte_t a);
        scratch_index = int'(a) % SCRATCH_DEPTH;
    endfunction : scratch_index

    // Field extraction; the instruction is used directly in the execute phase.
    assign op      = instr[`MCU8_OP_HI:`MCU8_OP_LO];
    assign sx      = instr[`MCU8_SX_HI:`MCU8_SX_LO];
    assign sy      = instr[`MCU8_SY_HI:`MCU8_SY_LO];
    assign cond    = instr[`MCU8_COND_HI:`MCU8_COND_LO];
    assign target  = instr[`MCU8_PC_W-1:0];
    assign val_x   = regs_r[sx];
    assign operand = instr[`MCU8_REGSRC_BIT] ? regs_r[sy] : instr[7:0];
    assign pc_inc  = pc_r + `MCU8_PC_W'(1);
    assign sp_inc  = (sp_r == 5'(STACK_DEPTH - 1)) ? 5'h00 : sp_r + 5'h01;
    assign sp_dec  = (sp_r == 5'h00) ? 5'(STACK_DEPTH - 1) : sp_r - 5'h01;
    assign cond_ok = cond_met(cond, zero_r, carry_r);

    assign exec = (phase_r == MCU8_PH_EXEC);
    // request seen twice
    // A request must have been high on the previous edge too, so glitches are ignored.
    assign take_int = exec & int_en_r & int_req & int_req_d_r;

    mcu8_alu u_alu (
        .op        (op),
        .shift_sel (instr[1:0]),
        .op_a      (val_x),
        .op_b      (operand),
        .carry_in  (carry_r),
        .result    (alu_res),
        .zero      (alu_zero),
        .carry     (alu_carry),
        .write_en  (alu_we)
    );

    // Phase toggles every cycle; nothing stalls the core.
    always_ff @(posedge clk) begin
        if (srst) begin
            phase_r <= MCU8_PH_FETCH;
        end else begin
            phase_r <= exec ? MCU8_PH_FETCH : MCU8_PH_EXEC;
        end
    end

    // Next program counter, chosen in the execute phase.
    always_comb begin
        pc_nxt = pc_inc;
        if (take_int) begin
            pc_nxt = `MCU8_INT_VECTOR;
        end else begin
            case (op)
                `MCU8_OP_JUMP, `MCU8_OP_CALL: begin
                    if (cond_ok) begin
                        pc_nxt = target;
                    end
                end
                `MCU8_OP_RETURN: begin
                    if (cond_ok) begin
                        pc_nxt = stack_r[sp_dec];
                    end
                end
                `MCU8_OP_RETI: pc_nxt = stack_r[sp_dec];
                default:       pc_nxt = pc_inc;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pc_r <= `MCU8_RESET_PC;
        end else if (exec) begin
            pc_r <= pc_nxt;
        end
    end
    assign instr_addr = pc_r;

    // call stack
    // The stack wraps on overflow; deep nesting silently overwrites the oldest entry.
    always_ff @(posedge clk) begin
        if (srst) begin
            sp_r <= 5'h00;
        end else if (exec) begin
            if (take_int || (op == `MCU8_OP_CALL && cond_ok)) begin
                // An interrupt saves the address of the instruction it displaced.
                stack_r[sp_r] <= take_int ? pc_r : pc_inc;
                sp_r          <= sp_inc;
            end else if ((op == `MCU8_OP_RETURN && cond_ok) || op == `MCU8_OP_RETI) begin
                sp_r <= sp_dec;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            zero_r  <= 1'b0;
            carry_r <= 1'b0;
        end else if (exec && !take_int) begin
            if (op <= `MCU8_OP_SHIFT && op != `MCU8_OP_LOAD) begin
                zero_r  <= alu_zero;
                carry_r <= alu_carry;
            end else if (op == `MCU8_OP_RETI) begin
                zero_r  <= zero_save_r;
                carry_r <= carry_save_r;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            int_en_r     <= 1'b0;
            int_req_d_r  <= 1'b0;
            int_ack      <= 1'b0;
            zero_save_r  <= 1'b0;
            carry_save_r <= 1'b0;
        end else begin
            int_req_d_r <= int_req;
            int_ack     <= take_int;
            if (take_int) begin
                int_en_r     <= 1'b0;
                zero_save_r  <= zero_r;
                carry_save_r <= carry_r;
            end else if (exec && (op == `MCU8_OP_RETI || op == `MCU8_OP_INTEN)) begin
                int_en_r <= instr[0];
            end
        end
    end

    // working registers
    // The input byte lands one cycle after the input instruction, before the next executes.
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_r[i] <= 8'h00;
            end
        end else if (read_pulse) begin
            regs_r[in_dest_r] <= in_port;
        end else if (exec && !take_int) begin
            if (op <= `MCU8_OP_SHIFT && alu_we) begin
                regs_r[sx] <= alu_res;
            end else if (op == `MCU8_OP_FETCH) begin
                regs_r[sx] <= scratch_r[scratch_index(operand)];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (exec && !take_int && op == `MCU8_OP_STORE) begin
            scratch_r[scratch_index(operand)] <= val_x;
        end
    end

    // port cycle
    // Address and data are registered with the strobe so all three change together.
    always_ff @(posedge clk) begin
        if (srst) begin
            io_select_address <= 8'h00;
            out_port          <= 8'h00;
            read_pulse        <= 1'b0;
            write_pulse       <= 1'b0;
            in_dest_r         <= 4'h0;
        end else begin
            read_pulse  <= 1'b0;
            write_pulse <= 1'b0;
            if (exec && !take_int && op == `MCU8_OP_INPUT) begin
                io_select_address <= operand;
                in_dest_r         <= sx;
                read_pulse        <= 1'b1;
            end else if (exec && !take_int && op == `MCU8_OP_OUTPUT) begin
                io_select_address <= operand;
                out_port          <= val_x;
                write_pulse       <= 1'b1;
            end
        end
    end
endmodule : mcu8_core

// ---- tb/t8mc_monitor.sv ----
// Concurrent checks on the ports of the microcontroller core.
module t8mc_monitor
    import mcu8_pkg::*;
(
    // Clock and reset.
    input wire logic       clk,
    input wire logic       srst,
    // Program store and port bus.
    input wire mcu8_pc_t   instr_addr,
    input wire mcu8_byte_t io_select_address,
    input wire mcu8_byte_t out_port,
    input wire logic       read_pulse,
    input wire logic       write_pulse,
    // Interrupt.
    input wire logic       int_req,
    input wire logic       int_ack
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    // A strobe is one high cycle followed by a low one.
    sequence s_read_once;
        read_pulse ##1 !read_pulse;
    endsequence
    sequence s_write_once;
        write_pulse ##1 !write_pulse;
    endsequence

    read_once_a: assert property (read_pulse |-> s_read_once)
        else $error("read pulse longer than one cycle");
    write_once_a: assert property (write_pulse |-> s_write_once)
        else $error("write pulse longer than one cycle");
    strobe_excl_a: assert property (!(read_pulse && write_pulse))
        else $error("read and write pulse together");
    pc_hold_a: assert property ($changed(instr_addr) |=> $stable(instr_addr))
        else $error("instruction address held one cycle only");
    // output data moves only on a write
    out_cause_a: assert property ($changed(out_port) |-> write_pulse)
        else $error("output data changed without write pulse");
    // port address moves only on an access
    sel_cause_a: assert property ($changed(io_select_address) |-> read_pulse || write_pulse)
        else $error("port address changed without strobe");
    ack_vector_a: assert property (int_ack |-> instr_addr == 10'h3ff)
        else $error("acknowledge without vector address");
    ack_cause_a: assert property (int_ack |-> $past(int_req, 2))
        else $error("acknowledge without request two cycles before");
    ack_once_a: assert property (int_ack |=> !int_ack [*2])
        else $error("acknowledge repeated");
endmodule : t8mc_monitor

bind mcu8_core t8mc_monitor i_t8mc_monitor (.clk(clk), .srst(srst), .instr_addr(instr_addr),
    .io_select_address(io_select_address), .out_port(out_port), .read_pulse(read_pulse),
    .write_pulse(write_pulse), .int_req(int_req), .int_ack(int_ack));

// ---- tb/t8mc_far_end.sv ----
// Program store and input port logic that face the microcontroller core.
module t8mc_far_end
    import mcu8_pkg::*;
(
    // Clock.
    input wire logic       clk,
    // Program store.
    input wire mcu8_pc_t   instr_addr,
    output mcu8_instr_t    instr,
    // Port bus.
    input wire mcu8_byte_t io_select_address,
    input wire logic       read_pulse,
    output mcu8_byte_t     in_port
);
    timeunit 1ns;
    timeprecision 1ns;

    mcu8_instr_t rom [0:1023];
    mcu8_byte_t  noise_r = 8'h00;

    // Word with a constant operand.
    function automatic mcu8_instr_t op_k(input logic [4:0] op, input logic [3:0] sx,
                                         input mcu8_byte_t k);
        return {op, 1'b0, sx, k};
    endfunction : op_k

    // Jump word with condition and target.
    function automatic mcu8_instr_t jmp(input logic [2:0] cc, input mcu8_pc_t t);
        return {5'h10, cc, t};
    endfunction : jmp

    // Test program; spare words hold an unknown opcode so a stray fetch does nothing.
    initial begin
        for (int a = 0; a < 1024; a++) begin
            rom[a] = 18'h3ffff;
        end
        rom[0] = op_k(5'h00, 4'h0, 8'h5a);
        rom[1] = op_k(5'h0c, 4'h0, 8'h12);
        rom[2] = op_k(5'h0b, 4'h1, 8'hf3);
        rom[3] = op_k(5'h0c, 4'h1, 8'h34);
        rom[4] = op_k(5'h00, 4'h2, 8'hff);
        rom[5] = op_k(5'h04, 4'h2, 8'h01);
        rom[6] = jmp(3'h4, 10'h008);
        rom[7] = op_k(5'h0c, 4'h2, 8'hee);
        rom[8] = jmp(3'h6, 10'h00a);
        rom[9] = op_k(5'h0c, 4'h2, 8'hee);
        rom[10] = op_k(5'h0c, 4'h2, 8'h56);
        rom[11] = {5'h14, 13'h0001};
        // The idle loop spins only while zero is set, so lost flags after the return show up.
        rom[12] = jmp(3'h4, 10'h00c);
        rom[13] = op_k(5'h0c, 4'h2, 8'hee);
        rom[14] = jmp(3'h0, 10'h00e);
        rom[10'h3ff] = jmp(3'h0, 10'h020);
        // Service routine: a nested call through scratch memory, then a return that keeps
        // interrupts off after clearing zero, which the return must restore.
        rom[10'h020] = op_k(5'h0c, 4'h0, 8'h77);
        rom[10'h021] = {5'h11, 3'h0, 10'h030};
        rom[10'h022] = op_k(5'h0c, 4'h4, 8'h78);
        rom[10'h023] = op_k(5'h04, 4'h3, 8'h01);
        rom[10'h024] = {5'h13, 13'h0000};
        rom[10'h030] = op_k(5'h0e, 4'h0, 8'h05);
        rom[10'h031] = op_k(5'h0d, 4'h4, 8'h05);
        rom[10'h032] = op_k(5'h06, 4'h4, 8'h1a);
        rom[10'h033] = {5'h12, 13'h0000};
    end

    assign instr = rom[instr_addr];

    // Idle bus drifts every cycle so a late sample never sees a stale byte.
    always @(posedge clk) begin
        noise_r <= noise_r + 8'h01;
    end
    assign in_port = read_pulse ? (io_select_address ^ 8'h3c) : noise_r;
endmodule : t8mc_far_end

// ---- tb/tiny_8bit_microcontroller_core_tb.sv ----
// Self-checking bench for the microcontroller core with its program store.
module tiny_8bit_microcontroller_core_tb
    import mcu8_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        int_req = 1'b0;
    mcu8_pc_t    instr_addr;
    mcu8_instr_t instr;
    mcu8_byte_t  io_select_address;
    mcu8_byte_t  out_port;
    mcu8_byte_t  in_port;
    logic        read_pulse;
    logic        write_pulse;
    logic        int_ack;
    int          err_total = 0;
    int          n_checks = 0;

    // Clock of 100 ns period.
    initial begin
        forever #50 clk = ~clk;
    end

    mcu8_core i_mcu8_core (.clk(clk), .srst(srst), .instr_addr(instr_addr), .instr(instr),
        .io_select_address(io_select_address), .out_port(out_port), .in_port(in_port),
        .read_pulse(read_pulse), .write_pulse(write_pulse), .int_req(int_req),
        .int_ack(int_ack));
    t8mc_far_end i_t8mc_far_end (.clk(clk), .instr_addr(instr_addr), .instr(instr),
        .io_select_address(io_select_address), .read_pulse(read_pulse), .in_port(in_port));

    // Compares one value and counts the outcome.
    task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // Prints the counts and the verdict, then stops.
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done

    // One cycle of a bounded wait; a hang ends the run instead of stalling it.
    task automatic tick(inout int n);
        @(negedge clk);
        n++;
        if (n > 200) begin
            err_total++;
            test_done();
        end
    endtask : tick

    task automatic wait_addr(input mcu8_pc_t a);
        int n;
        n = 0;
        while (instr_addr !== a) tick(n);
    endtask : wait_addr

    // Waits for a strobe, then judges address, output data on a write, and strobe width.
    task automatic wait_io(input logic wr, input mcu8_byte_t port, input mcu8_byte_t data);
        int n;
        n = 0;
        while ((wr ? write_pulse : read_pulse) !== 1'b1) tick(n);
        check(io_select_address, port, "port address");
        if (wr) check(out_port, data, "output data");
        @(negedge clk);
        check(wr ? write_pulse : read_pulse, 1'b0, "strobe width");
    endtask : wait_io

    task automatic t_reset();
        repeat (8) @(negedge clk);
        check(instr_addr, 10'h000, "reset address");
        check({read_pulse, write_pulse, int_ack}, 10'h000, "reset strobes");
        check(out_port, 8'h00, "reset data");
        srst = 1'b0;
        $display("done: reset");
    endtask : t_reset

    // Address 0x001 must stand for exactly two cycles.
    task automatic t_pc();
        int n;
        wait_addr(10'h001);
        n = 0;
        while (instr_addr === 10'h001 && n < 10) tick(n);
        check(n, 2, "cycles per instruction");
        check(instr_addr, 10'h002, "next address");
        $display("done: timing");
    endtask : t_pc

    // Write, read another port into a register, then write it out again.
    task automatic t_ports();
        wait_io(1'b1, 8'h12, 8'h5a);
        wait_io(1'b0, 8'hf3, 8'h00);
        wait_io(1'b1, 8'h34, 8'hcf);
        $display("done: ports");
    endtask : t_ports

    // 0xff plus 1 gives zero and carry; both branches must skip the stray writes.
    task automatic t_flags();
        wait_io(1'b1, 8'h56, 8'h00);
        $display("done: flags");
    endtask : t_flags

    task automatic t_irq();
        int n;
        wait_addr(10'h00c);
        n = 0;
        int_req = 1'b1;
        while (int_ack !== 1'b1) tick(n);
        check(n inside {[2:3]}, 1'b1, "acknowledge delay");
        check(instr_addr, 10'h3ff, "vector address");
        int_req = 1'b0;
        wait_io(1'b1, 8'h77, 8'h5a);
        $display("done: interrupt");
    endtask : t_irq

    // A call inside the service routine moves a byte through scratch memory and back.
    task automatic t_call();
        wait_io(1'b1, 8'h78, 8'h40);
        $display("done: call");
    endtask : t_call

    // The return keeps interrupts off, so a held request is ignored; restored flags keep
    // the idle loop spinning, so no stray write may appear.
    task automatic t_masked();
        logic seen;
        logic wr;
        seen = 1'b0;
        wr = 1'b0;
        int_req = 1'b1;
        repeat (12) begin
            @(negedge clk);
            seen = seen | (int_ack === 1'b1);
            wr = wr | (write_pulse === 1'b1);
        end
        int_req = 1'b0;
        check(seen, 1'b0, "acknowledge while disabled");
        check(wr, 1'b0, "flags after return");
        check(instr_addr, 10'h00c, "return address");
        $display("done: masked");
    endtask : t_masked

    // Main sequence.
    initial begin
        t_reset();
        t_pc();
        t_ports();
        t_flags();
        t_irq();
        t_call();
        t_masked();
        test_done();
    end
endmodule : tiny_8bit_microcontroller_core_tb
